// ===== verilog/peam_pkg.sv
// What this block does
// - raise position error overflow when error counter exceeds excess threshold
// - servo-on with off-time error above servo-on threshold raises overflow alarm
// - residual error at servo-on clamps speed to servo-on speed limit
// - limited speed plus new references and error over threshold raises alarm
// - accumulated position beyond plus or minus 1879048192 raises overflow alarm
// - fluctuating received transmission cycle raises internal sync error alarm
// - configured transmission cycle outside supported range raises setting alarm
// - watchdog field not advancing between cycles raises sync error alarm
// - selectable filter smooths acceleration of incoming position references
// - position error monitor readable, also while servo power is off
// - reference pulse total monitor shows accumulated position reference
package peam_pkg;
   localparam int             ERR_W         = 32;
   localparam int             POS_W         = 40;
   localparam int             SPD_W         = 16;
   localparam int             CYC_W         = 16;
   localparam int             WDT_W         = 4;
   localparam int             ALARM_N       = 7;
   localparam logic [POS_W-1:0] POS_LIMIT   = 40'h0070000000;
   localparam logic [CYC_W-1:0] CYC_MIN_DEF = 16'h0032;
   localparam logic [CYC_W-1:0] CYC_MAX_DEF = 16'h0320;
   localparam logic [CYC_W-1:0] CYC_TOL_DEF = 16'h0001;
   localparam int             FILT_SH       = 3;
   localparam int             AL_POS        = 0;
   localparam int             AL_SON        = 1;
   localparam int             AL_SPD        = 2;
   localparam int             AL_DATA       = 3;
   localparam int             AL_ISYNC      = 4;
   localparam int             AL_CYCSET     = 5;
   localparam int             AL_SYNC       = 6;
   typedef logic [ALARM_N-1:0] peam_alarm_t;
   typedef enum logic [1:0] {
      PEAM_OFF     = 2'b00,
      PEAM_LIMITED = 2'b01,
      PEAM_RUN     = 2'b11
   } peam_state_t;
   function automatic logic [ERR_W-1:0] peam_abs(input logic signed [ERR_W-1:0] v);
      peam_abs = v[ERR_W-1] ? ERR_W'(-v) : v;
   endfunction
endpackage

// ===== verilog/peam_ref_if.sv
`timescale 1ns/1ns
`default_nettype none
interface peam_ref_if;
   import peam_pkg::*;
   logic                    valid;
   logic signed [ERR_W-1:0] delta;
   modport src (output valid, output delta);
   modport dst (input valid, input delta);
endinterface
`default_nettype wire

// ===== verilog/peam_ref_filter.sv
`timescale 1ns/1ns
`default_nettype none
module peam_ref_filter
   import peam_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic                    ce,
   input  wire logic                    enable,
   input  wire logic                    ref_strobe,
   input  wire logic signed [ERR_W-1:0] ref_delta,
   peam_ref_if.src                      out
);
   import peam_pkg::*;
   // first-order smoothing; residue keeps the total exact so no counts are lost
   logic signed [ERR_W-1:0] resid_q;
   logic signed [ERR_W-1:0] sum;
   logic signed [ERR_W-1:0] step;
   assign sum  = resid_q + (ref_strobe ? ref_delta : '0);
   assign step = (sum >>> FILT_SH) != '0 ? (sum >>> FILT_SH) : sum;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resid_q   <= '0;
         out.valid <= 1'b0;
         out.delta <= '0;
      end else if (ce) begin
         if (enable) begin
            resid_q   <= sum - step;
            out.valid <= step != '0;
            out.delta <= step;
         end else begin
            resid_q   <= '0;
            out.valid <= ref_strobe || resid_q != '0;
            out.delta <= sum;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/peam_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module peam_monitor
   import peam_pkg::*;
#(
   parameter logic [CYC_W-1:0] CYC_MIN = CYC_MIN_DEF,
   parameter logic [CYC_W-1:0] CYC_MAX = CYC_MAX_DEF,
   parameter logic [CYC_W-1:0] CYC_TOL = CYC_TOL_DEF
)(
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic                    ce,
   input  wire logic                    servo_on,
   input  wire logic                    ref_strobe,
   input  wire logic signed [ERR_W-1:0] ref_delta,
   input  wire logic signed [ERR_W-1:0] feedback_delta,
   input  wire logic                    accel_filter_select,
   input  wire logic [ERR_W-1:0]        excess_error_threshold,
   input  wire logic [ERR_W-1:0]        servo_on_error_threshold,
   input  wire logic [SPD_W-1:0]        servo_on_speed_limit,
   input  wire logic [CYC_W-1:0]        cycle_setting,
   input  wire logic                    sync_pulse,
   input  wire logic [WDT_W-1:0]        host_watchdog_field,
   output logic signed [ERR_W-1:0]      position_error_monitor,
   output logic signed [POS_W-1:0]      reference_pulse_total_monitor,
   output logic [SPD_W-1:0]             speed_limit_out,
   output logic                         speed_limit_active,
   output peam_alarm_t                  alarms,
   output logic                         alarm_any
);
   import peam_pkg::*;

   peam_ref_if fref ();
   peam_ref_filter u_filt (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .ce         (ce),
      .enable     (accel_filter_select),
      .ref_strobe (ref_strobe),
      .ref_delta  (ref_delta),
      .out        (fref.src)
   );

   // pins from the host side cross two flops before use
   logic             sp_s1_q, sp_s2_q;
   logic [WDT_W-1:0] wd_s1_q, wd_s2_q;
   logic             sp_d3_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sp_s1_q <= '0;
         sp_s2_q <= '0;
         wd_s1_q <= '0;
         wd_s2_q <= '0;
         sp_d3_q <= 1'b0;
      end else if (ce) begin
         sp_s1_q <= sync_pulse;
         sp_s2_q <= sp_s1_q;
         wd_s1_q <= host_watchdog_field;
         wd_s2_q <= wd_s1_q;
         sp_d3_q <= sp_s2_q;
      end
   end
   logic sync_rise;
   assign sync_rise = sp_s2_q && !sp_d3_q;

   // error counter: references add, feedback subtracts; lives on with servo off
   logic signed [ERR_W-1:0] err_d;
   logic [ERR_W-1:0]        err_abs, err_d_abs;
   assign err_d     = position_error_monitor + (fref.valid ? fref.delta : '0) - feedback_delta;
   assign err_abs   = peam_abs(position_error_monitor);
   assign err_d_abs = peam_abs(err_d);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         position_error_monitor <= '0;
      end else if (ce) begin
         position_error_monitor <= err_d;
      end
   end

   logic signed [POS_W-1:0] tot_d;
   // widen the signed step first, so that negative references extend their sign
   assign tot_d = reference_pulse_total_monitor + (ref_strobe ? POS_W'(ref_delta) : '0);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reference_pulse_total_monitor <= '0;
      end else if (ce) begin
         reference_pulse_total_monitor <= tot_d;
      end
   end

   // servo-on supervision
   peam_state_t st_q;
   logic        son_q;
   logic        son_rise;
   assign son_rise = servo_on && !son_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         son_q <= 1'b0;
         st_q  <= PEAM_OFF;
      end else if (ce) begin
         son_q <= servo_on;
         unique case (st_q)
            PEAM_OFF:     if (son_rise) st_q <= (err_abs != '0) ? PEAM_LIMITED : PEAM_RUN;
            PEAM_LIMITED: if (!servo_on) st_q <= PEAM_OFF;
                          else if (err_abs == '0) st_q <= PEAM_RUN;
            PEAM_RUN:     if (!servo_on) st_q <= PEAM_OFF;
            default:      st_q <= PEAM_OFF;
         endcase
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         speed_limit_active <= 1'b0;
         speed_limit_out    <= '0;
      end else if (ce) begin
         speed_limit_active <= st_q == PEAM_LIMITED;
         speed_limit_out    <= servo_on_speed_limit;
      end
   end

   // transmission cycle measurement between host sync pulses
   logic [CYC_W-1:0] cnt_q, last_q;
   logic             seen_q;
   logic             have_q;
   logic [WDT_W-1:0] wd_last_q;
   logic             wd_have_q;
   logic             wd_chk_q;
   logic [CYC_W-1:0] cyc_diff;
   assign cyc_diff = cnt_q > last_q ? cnt_q - last_q : last_q - cnt_q;
   // the span from reset to the first pulse is no period, so jitter is judged from
   // the third pulse on; the watchdog word is read a cycle after the pulse edge so
   // that every bit of its own synchroniser has settled on the new value
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q     <= '0;
         last_q    <= '0;
         seen_q    <= 1'b0;
         have_q    <= 1'b0;
         wd_last_q <= '0;
         wd_have_q <= 1'b0;
         wd_chk_q  <= 1'b0;
      end else if (ce) begin
         wd_chk_q <= sync_rise;
         if (wd_chk_q) begin
            wd_last_q <= wd_s2_q;
            wd_have_q <= 1'b1;
         end
         if (sync_rise) begin
            cnt_q  <= CYC_W'(1);
            last_q <= cnt_q;
            seen_q <= 1'b1;
            have_q <= seen_q;
         end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + CYC_W'(1);
         end
      end
   end

   peam_alarm_t set;
   always_comb begin
      set               = '0;
      set[AL_POS]       = err_d_abs > excess_error_threshold;
      set[AL_SON]       = son_rise && st_q == PEAM_OFF
                          && err_abs > servo_on_error_threshold;
      set[AL_SPD]       = st_q == PEAM_LIMITED && fref.valid
                          && err_d_abs > excess_error_threshold;
      set[AL_DATA]      = tot_d > $signed(POS_LIMIT) || tot_d < -$signed(POS_LIMIT);
      set[AL_ISYNC]     = sync_rise && have_q && cyc_diff > CYC_TOL;
      set[AL_CYCSET]    = cycle_setting < CYC_MIN || cycle_setting > CYC_MAX;
      set[AL_SYNC]      = wd_chk_q && wd_have_q
                          && wd_s2_q != wd_last_q + WDT_W'(1);
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         alarms    <= '0;
         alarm_any <= 1'b0;
      end else if (ce) begin
         alarms    <= alarms | set;
         alarm_any <= |(alarms | set);
      end
   end

   a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      ce |=> (alarms & $past(alarms)) == $past(alarms))
      else $error("latched alarm dropped");
   a_pos_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && err_d_abs > excess_error_threshold |=> alarms[AL_POS])
      else $error("position error overflow missed");
   a_son_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && son_rise && st_q == PEAM_OFF && err_abs > servo_on_error_threshold
      |=> alarms[AL_SON])
      else $error("servo-on overflow missed");
   sequence s_limited_on;
      ce && son_rise && st_q == PEAM_OFF && err_abs != '0;
   endsequence
   a_limit_engage: assert property (@(posedge mclk) disable iff (!rst_n)
      s_limited_on ##1 ce |=> speed_limit_active)
      else $error("speed limit not applied");
   a_spd_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && st_q == PEAM_LIMITED && fref.valid && err_d_abs > excess_error_threshold
      |=> alarms[AL_SPD])
      else $error("speed-limit overflow missed");
   a_data_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && (reference_pulse_total_monitor > $signed(POS_LIMIT)
             || reference_pulse_total_monitor < -$signed(POS_LIMIT)) |=> alarms[AL_DATA])
      else $error("position data overflow missed");
   a_cyc_setting: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && (cycle_setting > CYC_MAX || cycle_setting < CYC_MIN) |=> alarms[AL_CYCSET])
      else $error("cycle setting alarm missed");
   a_wd_stuck: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && wd_chk_q && wd_have_q && wd_s2_q == wd_last_q |=> alarms[AL_SYNC])
      else $error("watchdog stall missed");
   a_cyc_jitter: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && sync_rise && have_q && cyc_diff > CYC_TOL |=> alarms[AL_ISYNC])
      else $error("cycle fluctuation missed");
   a_err_track: assert property (@(posedge mclk) disable iff (!rst_n)
      ce && !servo_on && !fref.valid && feedback_delta == '0
      |=> $stable(position_error_monitor))
      else $error("error monitor drifted while off");
endmodule
`default_nettype wire

// ===== test/peam_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module peam_host_model
   import peam_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              run,
   input  wire logic [CYC_W-1:0]  period,
   input  wire logic              wd_bad,
   output var  logic              sync_pulse,
   output var  logic [WDT_W-1:0]  host_watchdog_field
);
   int cnt;
   // pulse stays low while the host is stopped, so no stray cycle is measured
   always @(negedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt = 0;
         sync_pulse = 1'b0;
         host_watchdog_field = 4'h0;
      end else if (!run) begin
         cnt = 0;
         sync_pulse = 1'b0;
      end else begin
         cnt++;
         if (cnt >= period) begin
            cnt = 0;
            sync_pulse = 1'b1;
            if (!wd_bad) host_watchdog_field = host_watchdog_field + 4'h1;
         end else if (cnt == 2) begin
            sync_pulse = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import peam_pkg::*;
   logic mclk, rst_n, servo_on, ref_strobe, filt, sync_pulse, run, wd_bad, ce;
   logic signed [ERR_W-1:0] ref_delta, fb_delta, pos_err;
   logic signed [POS_W-1:0] total;
   logic [CYC_W-1:0] cyc_set, period;
   logic [WDT_W-1:0] wdf;
   logic [SPD_W-1:0] spd_out;
   logic spd_act, alarm_any;
   peam_alarm_t alarms;
   int err_count = 0;
   int n_checks = 0;
   peam_monitor peam_monitor_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .servo_on(servo_on),
      .ref_strobe(ref_strobe), .ref_delta(ref_delta), .feedback_delta(fb_delta),
      .accel_filter_select(filt), .excess_error_threshold(32'h000003E8),
      .servo_on_error_threshold(32'h00000064), .servo_on_speed_limit(16'h0040),
      .cycle_setting(cyc_set), .sync_pulse(sync_pulse), .host_watchdog_field(wdf),
      .position_error_monitor(pos_err), .reference_pulse_total_monitor(total),
      .speed_limit_out(spd_out), .speed_limit_active(spd_act), .alarms(alarms),
      .alarm_any(alarm_any));
   peam_host_model peam_host_model_i (.mclk(mclk), .rst_n(rst_n), .run(run), .period(period),
      .wd_bad(wd_bad), .sync_pulse(sync_pulse), .host_watchdog_field(wdf));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic do_reset();
      @(negedge mclk);
      rst_n = 1'b0;
      run = 1'b0;
      servo_on = 1'b0;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
   endtask
   task automatic strobe(input logic signed [ERR_W-1:0] d, input int settle);
      @(negedge mclk);
      ref_strobe = 1'b1;
      ref_delta = d;
      @(negedge mclk);
      ref_strobe = 1'b0;
      ref_delta = '0;
      repeat (settle) @(negedge mclk);
   endtask
   task automatic t_monitor();
      do_reset();
      chk("alarms after reset", 40'h0, {33'h0, alarms});
      strobe(32'sh5, 3);
      chk("error monitor", 40'h5, {8'h0, pos_err});
      chk("reference total", 40'h5, total);
      $display("test monitor done");
   endtask
   task automatic t_pos_err();
      do_reset();
      servo_on = 1'b1;
      strobe(32'sh3E8, 3);
      chk("no alarm at threshold", 40'h0, {39'h0, alarms[AL_POS]});
      strobe(32'sh1, 3);
      chk("position error alarm", 40'h1, {39'h0, alarms[AL_POS]});
      fb_delta = 32'sh3E9;
      @(negedge mclk);
      fb_delta = '0;
      repeat (3) @(negedge mclk);
      chk("error drained", 40'h0, {8'h0, pos_err});
      chk("alarm latched", 40'h1, {39'h0, alarms[AL_POS]});
      chk("any alarm", 40'h1, {39'h0, alarm_any});
      $display("test position error done");
   endtask
   task automatic t_servo_on();
      do_reset();
      strobe(32'sh64, 2);
      servo_on = 1'b1;
      repeat (3) @(negedge mclk);
      chk("servo-on at threshold", 40'h0, {39'h0, alarms[AL_SON]});
      servo_on = 1'b0;
      strobe(32'sh1, 2);
      servo_on = 1'b1;
      repeat (3) @(negedge mclk);
      chk("servo-on alarm", 40'h1, {39'h0, alarms[AL_SON]});
      chk("limit active", 40'h1, {39'h0, spd_act});
      chk("limit value", 40'h40, {24'h0, spd_out});
      strobe(32'sh3E8, 3);
      chk("limited overflow", 40'h1, {39'h0, alarms[AL_SPD]});
      $display("test servo on done");
   endtask
   task automatic t_pos_data();
      do_reset();
      strobe(32'sh38000000, 0);
      strobe(32'sh38000000, 3);
      chk("data at limit", 40'h0, {39'h0, alarms[AL_DATA]});
      strobe(32'sh1, 3);
      chk("data beyond limit", 40'h1, {39'h0, alarms[AL_DATA]});
      do_reset();
      strobe(-32'sh38000000, 0);
      strobe(-32'sh38000000, 3);
      chk("negative total", 40'hFF90000000, total);
      chk("data at minus limit", 40'h0, {39'h0, alarms[AL_DATA]});
      strobe(-32'sh1, 3);
      chk("data beyond minus limit", 40'h1, {39'h0, alarms[AL_DATA]});
      $display("test position data done");
   endtask
   task automatic t_freeze();
      do_reset();
      ce = 1'b0;
      strobe(32'sh7, 2);
      chk("frozen error", 40'h0, {8'h0, pos_err});
      chk("frozen total", 40'h0, total);
      ce = 1'b1;
      repeat (3) @(negedge mclk);
      chk("error after thaw", 40'h0, {8'h0, pos_err});
      $display("test freeze done");
   endtask
   task automatic t_filter();
      do_reset();
      filt = 1'b1;
      strobe(32'sh320, 2);
      chk("smoothed step", 40'h1, {39'h0, pos_err < 32'sh320});
      filt = 1'b0;
      $display("test filter done");
   endtask
   task automatic host_run(input logic [CYC_W-1:0] p, input logic bad, input int n);
      period = p;
      wd_bad = bad;
      run = 1'b1;
      repeat (n * 100) @(negedge mclk);
   endtask
   task automatic t_link();
      do_reset();
      cyc_set = 16'h0064;
      host_run(16'h0064, 1'b0, 6);
      chk("steady link", 40'h0, {33'h0, alarms});
      host_run(16'h006E, 1'b0, 3);
      chk("cycle fluctuation", 40'h1, {39'h0, alarms[AL_ISYNC]});
      do_reset();
      host_run(16'h0064, 1'b1, 4);
      chk("watchdog stuck", 40'h1, {39'h0, alarms[AL_SYNC]});
      do_reset();
      cyc_set = 16'h0010;
      host_run(16'h0064, 1'b0, 4);
      chk("cycle setting", 40'h1, {39'h0, alarms[AL_CYCSET]});
      $display("test link done");
   endtask
   initial begin
      {rst_n, servo_on, ref_strobe, filt, run, wd_bad} = 6'b0;
      ce = 1'b1;
      ref_delta = '0;
      fb_delta = '0;
      cyc_set = 16'h0064;
      period = 16'h0064;
      t_monitor();
      t_pos_err();
      t_servo_on();
      t_pos_data();
      t_filter();
      t_freeze();
      t_link();
      tally_and_finish();
   end
   // the tests need about 1800 cycles, the limit is nearly fourteen times that
   initial begin
      #250000;
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
